/* File: inc/cfg_port_pkg.sv */
// Constants and types shared by the byte-wide configuration slave port
package cfg_port_pkg;

   // Core clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;

   // Config clock rate above which the busy handshake is used
   localparam int HANDSHAKE_FREQ_THRESHOLD_MHZ = 50;

   // Rate measurement window and the edge count that marks a fast clock
   localparam int RATE_WINDOW_NS = 640;
   localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_NS / CLK_PERIOD_NS;
   localparam int RATE_FAST_EDGES =
      (RATE_WINDOW_NS * HANDSHAKE_FREQ_THRESHOLD_MHZ) / 1000;
   localparam int RATE_CNT_W = 8;

   // Config clock edges that busy stays high after an abort starts
   localparam int ABORT_CYCLES = 4;
   localparam int ABORT_CNT_W = 3;

   // Synchronisation word that realigns the byte stream
   localparam logic [31:0] SYNC_WORD_DEFAULT = 32'h5A5A_C3C3;

   // Mode pin patterns, bit 0 is the first pin
   localparam logic [2:0] MODE_PAT_PARALLEL = 3'h6;
   localparam logic [1:0] MODE_PAT_MASTER_SERIAL = 2'h0;
   localparam logic [1:0] MODE_PAT_SLAVE_SERIAL = 2'h3;
   localparam logic [1:0] MODE_PAT_TEST_PORT = 2'h1;

   // Reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;

   // Decoded configuration mode, one-hot
   typedef enum logic [4:0] {
      MODE_NONE = 5'b0_0001,
      MODE_MASTER_SERIAL = 5'b0_0010,
      MODE_SLAVE_SERIAL = 5'b0_0100,
      MODE_SLAVE_PARALLEL = 5'b0_1000,
      MODE_TEST_PORT = 5'b1_0000
   } cfg_mode_t;

endpackage : cfg_port_pkg

/* File: hdl/cfg_sync2.sv */
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ns
`default_nettype none
module cfg_sync2 #(
   parameter int WIDTH = 1
) (
   // Destination clock
   input wire logic clk,
   // Level from the other domain and its synchronised copy
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] hold_ff;

   always_ff @(posedge clk) begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
   end

   assign sync_out = hold_ff;

endmodule : cfg_sync2
`default_nettype wire

/* File: hdl/cfg_parallel_port.sv */
// Byte-wide configuration slave port: link-side capture and core-side status
//
// Functional notes
// - Pattern 011 on mode pins selects parallel
// - 00x master serial, 11x slave serial
// - 10x selects test port, locks other modes
// - Capture byte on edge when selected, writing, idle
// - Busy high: byte refused, taken after busy falls
// - Busy after a byte only above fifty megahertz config clock
// - Deselected port ignores config clock edges
// - Write released under select starts abort
// - Busy held high until abort completes
// - After abort, wait for new sync word
// - Packets may span several select windows
// - Readback drives bus when write released
`timescale 1ns/1ns
`default_nettype none
module cfg_parallel_port #(
   parameter int ABORT_LEN = cfg_port_pkg::ABORT_CYCLES,
   parameter logic [31:0] SYNC_WORD = cfg_port_pkg::SYNC_WORD_DEFAULT
) (
   // Core clock and synchronous reset
   input wire logic clk,
   input wire logic rst,
   // Configuration link, clocked by config_clock
   input wire logic config_clock,
   input wire logic select_n,
   input wire logic write_n,
   input wire logic [7:0] config_byte_bus_in,
   output logic [7:0] config_byte_bus_out,
   output logic config_byte_bus_oe,
   output logic busy,
   // Mode straps
   input wire logic [2:0] mode_select_pins,
   // Core side status
   input wire logic config_done,
   output cfg_port_pkg::cfg_mode_t mode,
   output logic test_port_lock,
   output logic fast_clock,
   output logic stream_aligned,
   // Link side byte stream
   output logic [7:0] cfg_byte,
   output logic cfg_byte_valid,
   input wire logic [7:0] readback_byte,
   output logic readback_take
);

   generate
      if (ABORT_LEN < 1 || ABORT_LEN > (2 ** cfg_port_pkg::ABORT_CNT_W) - 1)
      begin : g_bad_abort
         $error("ABORT_LEN out of range for abort counter");
      end
   endgenerate

   localparam logic [cfg_port_pkg::ABORT_CNT_W-1:0] ABORT_LOAD =
      cfg_port_pkg::ABORT_CNT_W'(ABORT_LEN);

   function automatic logic [7:0] bit_reverse(input logic [7:0] b);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction : bit_reverse

   // ---------------- Core clock domain ----------------

   logic [2:0] mode_pins_s;
   cfg_port_pkg::cfg_mode_t mode_ff;
   cfg_port_pkg::cfg_mode_t nxt_mode;
   logic test_lock_ff;
   logic fast_ff;
   logic aligned_core_ff;
   logic aligned_s;
   logic edge_tgl_s;
   logic edge_tgl_d_ff;
   logic [cfg_port_pkg::RATE_CNT_W-1:0] win_cnt_ff;
   logic [cfg_port_pkg::RATE_CNT_W-1:0] edge_cnt_ff;
   // Link-side flops that the core side watches through synchronisers
   logic edge_tgl_ff;
   logic aligned_ff;

   cfg_sync2 #(.WIDTH(3)) u_mode_sync (
      .clk(clk),
      .async_in(mode_select_pins),
      .sync_out(mode_pins_s)
   );

   always_comb begin
      nxt_mode = cfg_port_pkg::MODE_NONE;
      if (mode_pins_s == cfg_port_pkg::MODE_PAT_PARALLEL) begin
         nxt_mode = cfg_port_pkg::MODE_SLAVE_PARALLEL;
      end else if (mode_pins_s[1:0] == cfg_port_pkg::MODE_PAT_MASTER_SERIAL)
      begin
         nxt_mode = cfg_port_pkg::MODE_MASTER_SERIAL;
      end else if (mode_pins_s[1:0] == cfg_port_pkg::MODE_PAT_SLAVE_SERIAL)
      begin
         nxt_mode = cfg_port_pkg::MODE_SLAVE_SERIAL;
      end else if (mode_pins_s[1:0] == cfg_port_pkg::MODE_PAT_TEST_PORT) begin
         nxt_mode = cfg_port_pkg::MODE_TEST_PORT;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= cfg_port_pkg::MODE_NONE;
         test_lock_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         test_lock_ff <= (nxt_mode == cfg_port_pkg::MODE_TEST_PORT);
      end
   end

   // Config clock rate: count link edges over a fixed core window
   cfg_sync2 #(.WIDTH(1)) u_edge_sync (
      .clk(clk),
      .async_in(edge_tgl_ff),
      .sync_out(edge_tgl_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         edge_tgl_d_ff <= 1'b0;
         win_cnt_ff <= '0;
         edge_cnt_ff <= '0;
         fast_ff <= 1'b0;
      end else begin
         edge_tgl_d_ff <= edge_tgl_s;
         if (win_cnt_ff ==
             cfg_port_pkg::RATE_CNT_W'(cfg_port_pkg::RATE_WINDOW_CYCLES - 1))
         begin
            win_cnt_ff <= '0;
            edge_cnt_ff <= '0;
            fast_ff <= edge_cnt_ff >
               cfg_port_pkg::RATE_CNT_W'(cfg_port_pkg::RATE_FAST_EDGES);
         end else begin
            win_cnt_ff <= win_cnt_ff + 1'b1;
            if (edge_tgl_s != edge_tgl_d_ff) begin
               edge_cnt_ff <= edge_cnt_ff + 1'b1;
            end
         end
      end
   end

   cfg_sync2 #(.WIDTH(1)) u_aligned_sync (
      .clk(clk),
      .async_in(aligned_ff),
      .sync_out(aligned_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         aligned_core_ff <= 1'b0;
      end else begin
         aligned_core_ff <= aligned_s;
      end
   end

   assign mode = mode_ff;
   assign test_port_lock = test_lock_ff;
   assign fast_clock = fast_ff;
   assign stream_aligned = aligned_core_ff;

   // ---------------- Config clock domain ----------------

   logic rst_link;
   logic par_en_l;
   logic fast_l;
   logic done_l;
   logic sel;
   logic wr;
   logic take;
   logic abort_start;
   logic [7:0] rx_byte;
   logic [cfg_port_pkg::ABORT_CNT_W-1:0] nxt_abort_cnt;
   logic prev_sel_ff;
   logic prev_wr_ff;
   logic busy_ff;
   logic [cfg_port_pkg::ABORT_CNT_W-1:0] abort_cnt_ff;
   logic [31:0] shift_ff;
   logic [7:0] byte_ff;
   logic byte_valid_ff;
   logic [7:0] bus_out_ff;
   logic bus_oe_ff;
   logic rb_take_ff;

   cfg_sync2 #(.WIDTH(4)) u_link_sync (
      .clk(config_clock),
      .async_in({rst, mode_ff == cfg_port_pkg::MODE_SLAVE_PARALLEL, fast_ff,
                 config_done}),
      .sync_out({rst_link, par_en_l, fast_l, done_l})
   );

   assign sel = ~select_n;
   assign wr = ~write_n;
   assign rx_byte = bit_reverse(config_byte_bus_in);

   // Write level changing under continued select before done is an abort
   assign abort_start = par_en_l && !done_l && sel && prev_sel_ff &&
                        (wr != prev_wr_ff) && (abort_cnt_ff == '0);
   assign take = par_en_l && !done_l && sel && wr && !busy_ff &&
                 !abort_start;

   always_comb begin
      nxt_abort_cnt = abort_cnt_ff;
      if (abort_start) begin
         nxt_abort_cnt = ABORT_LOAD;
      end else if (abort_cnt_ff != '0) begin
         nxt_abort_cnt = abort_cnt_ff - 1'b1;
      end
   end

   // Edge toggle feeds the rate monitor; runs only while the clock does
   always_ff @(posedge config_clock) begin
      if (rst_link) begin
         edge_tgl_ff <= 1'b0;
      end else begin
         edge_tgl_ff <= ~edge_tgl_ff;
      end
   end

   // Pin history for abort detection; select windows may come and go
   always_ff @(posedge config_clock) begin
      if (rst_link) begin
         prev_sel_ff <= 1'b0;
         prev_wr_ff <= 1'b0;
      end else begin
         prev_sel_ff <= sel;
         prev_wr_ff <= wr;
      end
   end

   always_ff @(posedge config_clock) begin
      if (rst_link) begin
         abort_cnt_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         abort_cnt_ff <= nxt_abort_cnt;
         // One busy edge after each byte only on a fast clock
         busy_ff <= (nxt_abort_cnt != '0) || (take && fast_l);
      end
   end

   // Alignment: hunt for the sync word, then pass bytes through
   always_ff @(posedge config_clock) begin
      if (rst_link) begin
         aligned_ff <= 1'b0;
         shift_ff <= cfg_port_pkg::SHIFT_RESET;
         byte_ff <= cfg_port_pkg::BYTE_RESET;
         byte_valid_ff <= 1'b0;
      end else begin
         byte_valid_ff <= 1'b0;
         if (abort_start) begin
            aligned_ff <= 1'b0;
            shift_ff <= cfg_port_pkg::SHIFT_RESET;
         end else if (take) begin
            if (aligned_ff) begin
               byte_ff <= rx_byte;
               byte_valid_ff <= 1'b1;
            end else begin
               shift_ff <= {shift_ff[23:0], rx_byte};
               if ({shift_ff[23:0], rx_byte} == SYNC_WORD) begin
                  aligned_ff <= 1'b1;
               end
            end
         end
      end
   end

   // Readback after configuration: write released under select
   always_ff @(posedge config_clock) begin
      if (rst_link) begin
         bus_out_ff <= cfg_port_pkg::BYTE_RESET;
         bus_oe_ff <= 1'b0;
         rb_take_ff <= 1'b0;
      end else begin
         bus_oe_ff <= par_en_l && done_l && sel && !wr;
         rb_take_ff <= par_en_l && done_l && sel && !wr;
         bus_out_ff <= readback_byte;
      end
   end

   assign busy = busy_ff;
   assign cfg_byte = byte_ff;
   assign cfg_byte_valid = byte_valid_ff;
   assign config_byte_bus_out = bus_out_ff;
   assign config_byte_bus_oe = bus_oe_ff;
   assign readback_take = rb_take_ff;

   // ---------------- Assertions ----------------

   property p_mode_parallel;
      @(posedge clk) disable iff (rst)
      mode_pins_s == cfg_port_pkg::MODE_PAT_PARALLEL |=>
         mode_ff == cfg_port_pkg::MODE_SLAVE_PARALLEL;
   endproperty
   a_mode_parallel: assert property (p_mode_parallel)
      else $error("parallel pattern did not select parallel mode");

   property p_mode_serial;
      @(posedge clk) disable iff (rst)
      mode_pins_s[1:0] == cfg_port_pkg::MODE_PAT_SLAVE_SERIAL |=>
         mode_ff == cfg_port_pkg::MODE_SLAVE_SERIAL;
   endproperty
   a_mode_serial: assert property (p_mode_serial)
      else $error("slave serial pattern not decoded");

   property p_test_lock;
      @(posedge clk) disable iff (rst)
      mode_pins_s[1:0] == cfg_port_pkg::MODE_PAT_TEST_PORT |=>
         test_lock_ff && mode_ff == cfg_port_pkg::MODE_TEST_PORT;
   endproperty
   a_test_lock: assert property (p_test_lock)
      else $error("test port pattern did not lock other modes");

   property p_capture;
      @(posedge config_clock) disable iff (rst_link)
      take && aligned_ff |=>
         byte_valid_ff && byte_ff == bit_reverse($past(config_byte_bus_in));
   endproperty
   a_capture: assert property (p_capture)
      else $error("byte not captured bit reversed");

   property p_busy_refuse;
      @(posedge config_clock) disable iff (rst_link)
      busy_ff && sel && wr |=> !byte_valid_ff;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse)
      else $error("byte taken while busy");

   property p_slow_no_busy;
      @(posedge config_clock) disable iff (rst_link)
      !fast_l && nxt_abort_cnt == '0 |=> !busy_ff;
   endproperty
   a_slow_no_busy: assert property (p_slow_no_busy)
      else $error("busy raised on slow clock without abort");

   property p_deselect_idle;
      @(posedge config_clock) disable iff (rst_link)
      !sel && abort_cnt_ff == '0 |=>
         !byte_valid_ff && $stable(aligned_ff) && $stable(shift_ff);
   endproperty
   a_deselect_idle: assert property (p_deselect_idle)
      else $error("state changed while deselected");

   property p_abort_busy;
      @(posedge config_clock) disable iff (rst_link)
      abort_start |=> busy_ff [*4] ##1 (ABORT_LEN != 4 || !busy_ff || take);
   endproperty
   a_abort_busy: assert property (p_abort_busy)
      else $error("busy not held for the abort");

   property p_abort_realign;
      @(posedge config_clock) disable iff (rst_link)
      abort_start |=> !aligned_ff && shift_ff == cfg_port_pkg::SHIFT_RESET;
   endproperty
   a_abort_realign: assert property (p_abort_realign)
      else $error("alignment kept after abort");

   property p_readback;
      @(posedge config_clock) disable iff (rst_link)
      par_en_l && done_l && sel && !wr |=>
         bus_oe_ff && bus_out_ff == $past(readback_byte);
   endproperty
   a_readback: assert property (p_readback)
      else $error("readback did not drive the bus");

   property p_idle_busy_low;
      @(posedge config_clock) disable iff (rst_link)
      !sel && nxt_abort_cnt == '0 |=> !busy_ff;
   endproperty
   a_idle_busy_low: assert property (p_idle_busy_low)
      else $error("busy high on an idle port");

endmodule : cfg_parallel_port
`default_nettype wire

/* File: verification/cfg_controller_model.sv */
// Configuration controller model that drives the byte-wide slave port
`timescale 1ns/1ns
`default_nettype none
module cfg_controller_model (
   // Link pins driven by the controller
   output var logic config_clock,
   output var logic select_n,
   output var logic write_n,
   output var logic [7:0] bus_drv,
   // Link pins watched by the controller
   input wire logic busy,
   input wire logic [7:0] bus_in
);
   // Clock runs between windows too; a deselected port ignores it
   initial begin
      config_clock = 1'b0;
      select_n = 1'b1;
      write_n = 1'b1;
      bus_drv = 8'h00;
      #3;
      forever #16 config_clock = ~config_clock;
   end

   function automatic logic [7:0] rev8(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         rev8[i] = b[7-i];
   endfunction : rev8

   // Callers enter and leave these tasks just after a rising edge
   task automatic send_byte(input logic [7:0] b);
      select_n <= 1'b0;
      write_n <= 1'b0;
      bus_drv <= rev8(b);
      for (int i = 0; i < 20; i++) begin
         @(posedge config_clock);
         if (busy === 1'b0) break;
      end
   endtask : send_byte

   // Deselect while the next byte is fetched; write stays asserted
   task automatic idle_edges(input int n);
      select_n <= 1'b1;
      for (int i = 0; i < n; i++) begin
         bus_drv <= ~bus_drv;
         @(posedge config_clock);
      end
   endtask : idle_edges

   task automatic end_window();
      select_n <= 1'b1;
      write_n <= 1'b1;
      bus_drv <= ~bus_drv;
      @(posedge config_clock);
   endtask : end_window

   // Returns busy as seen at the edge after the abort edge
   task automatic abort_now(output logic b);
      write_n <= 1'b1;
      bus_drv <= ~bus_drv;
      @(posedge config_clock);
      select_n <= 1'b1;
      @(posedge config_clock);
      b = busy;
   endtask : abort_now

   task automatic read_byte(output logic [7:0] d);
      select_n <= 1'b0;
      write_n <= 1'b1;
      bus_drv <= ~bus_drv;
      repeat (2) @(posedge config_clock);
      d = bus_in;
   endtask : read_byte
endmodule : cfg_controller_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the byte-wide configuration slave port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int ABORT_LEN = 4;
   localparam logic [31:0] SYNC = cfg_port_pkg::SYNC_WORD_DEFAULT;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] mode_select_pins = 3'h6;
   logic config_done = 1'b0;
   logic [7:0] readback_byte = 8'h00;
   logic config_clock;
   logic select_n;
   logic write_n;
   logic [7:0] bus_drv;
   logic [7:0] bus_wire;
   logic [7:0] config_byte_bus_out;
   logic config_byte_bus_oe;
   logic busy;
   cfg_port_pkg::cfg_mode_t mode;
   logic test_port_lock;
   logic fast_clock;
   logic stream_aligned;
   logic [7:0] cfg_byte;
   logic cfg_byte_valid;
   logic readback_take;
   logic [7:0] got_q[$];
   logic b;
   logic [7:0] d;
   int error_cnt = 0;
   int samples_checked = 0;
   int busy_cnt = 0;
   int cyc = 0;

   always #5 clk = ~clk;
   assign bus_wire = config_byte_bus_oe ? config_byte_bus_out : bus_drv;

   cfg_parallel_port #(.ABORT_LEN(ABORT_LEN)) dut (
      .clk(clk), .rst(rst), .config_clock(config_clock),
      .select_n(select_n), .write_n(write_n),
      .config_byte_bus_in(bus_wire),
      .config_byte_bus_out(config_byte_bus_out),
      .config_byte_bus_oe(config_byte_bus_oe), .busy(busy),
      .mode_select_pins(mode_select_pins), .config_done(config_done),
      .mode(mode), .test_port_lock(test_port_lock),
      .fast_clock(fast_clock), .stream_aligned(stream_aligned),
      .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
      .readback_byte(readback_byte), .readback_take(readback_take)
   );

   cfg_controller_model m (
      .config_clock(config_clock), .select_n(select_n),
      .write_n(write_n), .bus_drv(bus_drv), .busy(busy),
      .bus_in(bus_wire)
   );

   // Collects accepted bytes and counts busy edges
   always @(posedge config_clock) begin
      if (cfg_byte_valid === 1'b1)
         got_q.push_back(cfg_byte);
      if (busy === 1'b1)
         busy_cnt++;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic check_q(input logic [7:0] exp[$]);
      check("stream count", got_q.size(), exp.size());
      foreach (exp[i])
         check("stream byte", got_q[i], exp[i]);
   endtask : check_q

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   function automatic cfg_port_pkg::cfg_mode_t exp_mode(
      input logic [2:0] p);
      case (p[1:0])
         2'h0: return cfg_port_pkg::MODE_MASTER_SERIAL;
         2'h3: return cfg_port_pkg::MODE_SLAVE_SERIAL;
         2'h1: return cfg_port_pkg::MODE_TEST_PORT;
         default: return p[2] ? cfg_port_pkg::MODE_SLAVE_PARALLEL :
                                cfg_port_pkg::MODE_NONE;
      endcase
   endfunction : exp_mode

   task automatic send_sync(input int first, input int last);
      for (int k = first; k <= last; k++)
         m.send_byte(SYNC[31-8*k -: 8]);
   endtask : send_sync

   task automatic sc_modes();
      logic [2:0] p;
      for (int i = 0; i < 8; i++) begin
         p = 3'(i);
         @(posedge clk);
         mode_select_pins <= p;
         repeat (6) @(posedge clk);
         check("mode", mode, exp_mode(p));
         check("test lock", test_port_lock, p[1:0] == 2'h1);
      end
      @(posedge clk);
      mode_select_pins <= 3'h6;
      repeat (16) @(posedge clk);
   endtask : sc_modes

   // Sync, then bytes split over windows with write held low between
   task automatic sc_stream();
      got_q.delete();
      busy_cnt = 0;
      @(posedge config_clock);
      send_sync(0, 3);
      m.idle_edges(3);
      m.send_byte(8'h81);
      m.idle_edges(2);
      m.send_byte(8'h17);
      m.send_byte(8'hE4);
      m.end_window();
      repeat (4) @(posedge config_clock);
      check("aligned", stream_aligned, 1'b1);
      check_q('{8'h81, 8'h17, 8'hE4});
      check("busy edges", busy_cnt, 0);
      check("fast clock", fast_clock, 1'b0);
      check("busy idle", busy, 1'b0);
   endtask : sc_stream

   // First sync byte after the abort meets busy and must be held
   task automatic sc_abort();
      got_q.delete();
      @(posedge config_clock);
      m.send_byte(8'h42);
      busy_cnt = 0;
      m.abort_now(b);
      check("busy at abort", b, 1'b1);
      send_sync(0, 1);
      check("aligned after abort", stream_aligned, 1'b0);
      send_sync(2, 3);
      m.send_byte(8'hC5);
      m.end_window();
      repeat (4) @(posedge config_clock);
      check("abort busy edges", busy_cnt, ABORT_LEN);
      check_q('{8'h42, 8'hC5});
      check("aligned again", stream_aligned, 1'b1);
   endtask : sc_abort

   task automatic sc_readback();
      @(posedge clk);
      config_done <= 1'b1;
      @(posedge config_clock);
      readback_byte <= 8'h3C;
      repeat (4) @(posedge config_clock);
      m.read_byte(d);
      // Next byte for the following read; readback_take pulses each edge, but the byte changes once per two-edge read_byte
      readback_byte <= {readback_byte[3:0], readback_byte[7:4]};
      check("readback", d, 8'h3C);
      check("readback take", readback_take, 1'b1);
      m.read_byte(d);
      check("readback next", d, 8'hC3);
      m.end_window();
      repeat (2) @(posedge config_clock);
      check("bus drive off", config_byte_bus_oe, 1'b0);
      check("busy idle", busy, 1'b0);
   endtask : sc_readback

   // Reset spans enough link edges for the link-side reset to land
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge config_clock);
      sc_modes();
      sc_stream();
      sc_abort();
      sc_readback();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
